// ===== fawp_top.sv
// Operation
// [RULE1] program only clears bits, erase only sets them
// [RULE2] erase by subsector, sector or whole array; page erase refused
// [RULE3] array of 33,554,432 bytes in 512 sectors of 64KB
// [RULE4] 8192 subsectors of 4KB and 131,072 pages of 256 bytes
// [RULE5] 64-byte one-time area lies outside main array addresses
// [RULE6] any single 256-byte page may be programmed alone
// [RULE7] modifying commands need clock pulses forming whole bytes
// [RULE8] write-enable latch must be set before any modifying command
// [RULE9] set write-lock bit refuses program and erase in its sector
// [RULE10] set lock-down bit freezes sector protection until reset
// [RULE11] lock bits change only by lock write, refused when locked down
// [RULE12] lock write is the only updater of lock bits
// [RULE13] every sector starts write-locked after reset
// [RULE14] bottom bit 0: n protects top 2^(n-1) sectors, 10+ all
// [RULE15] bottom bit 1: n protects low 2^(n-1) sectors, 10+ all
// [RULE16] protect bits fixed while write-protect pin is low
// [RULE17] sector from address bits 24:16, subsector from 24:12
// [RULE18] refuse if any targeted sector protected; bulk if any protected
//
// Chosen here: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "fawp_cfg.svh"

module fawp_top
  import fawp_pkg::*;
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [7:0]   awaddr,
  input  wire logic         awvalid,
  output logic              awready,
  input  wire logic [31:0]  wdata,
  input  wire logic [3:0]   wstrb,
  input  wire logic         wvalid,
  output logic              wready,
  output logic [1:0]        bresp,
  output logic              bvalid,
  input  wire logic         bready,
  input  wire logic [7:0]   araddr,
  input  wire logic         arvalid,
  output logic              arready,
  output logic [31:0]       rdata,
  output logic [1:0]        rresp,
  output logic              rvalid,
  input  wire logic         rready,
  input  wire logic         write_protect_n,
  output logic              grant_valid,
  output fawp_grant_s       grant,
  output logic              reject_valid,
  output logic              wel
);

  // bus channel state
  logic        aw_have_r, aw_have_nxt;
  logic [7:0]  aw_addr_r, aw_addr_nxt;
  logic        w_have_r, w_have_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0]  w_strb_r, w_strb_nxt;
  logic        awready_r, awready_nxt;
  logic        wready_r, wready_nxt;
  logic        bvalid_r, bvalid_nxt;
  logic [1:0]  bresp_r, bresp_nxt;
  logic        arready_r, arready_nxt;
  logic        rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0]  rresp_r, rresp_nxt;
  logic        wr_fire;
  logic        wr_ok;
  logic [31:0] rd_word;
  logic        rd_ok;

  // software registers
  logic [`FAWP_ADDR_W-1:0] addr_r, addr_nxt;
  logic [31:0]             data_r, data_nxt;
  logic [31:0]             old_r, old_nxt;
  logic [3:0]              code_r, code_nxt;
  fawp_cmd_s               cmd_r, cmd_nxt;
  logic                    cmd_go_r, cmd_go_nxt;
  logic [31:0]             wr_word;

  // protection state
  logic [`FAWP_SECTORS-1:0] wlock_r, wlock_nxt;
  logic [`FAWP_SECTORS-1:0] ldown_r, ldown_nxt;
  fawp_prot_s               prot_r, prot_nxt;
  logic                     wel_r, wel_nxt;
  fawp_res_e                res_r, res_nxt;
  logic [31:0]              merged_r, merged_nxt;
  fawp_grant_s              grant_r, grant_nxt;
  logic                     grant_valid_r, grant_valid_nxt;
  logic                     reject_valid_r, reject_valid_nxt;

  // decision helpers
  logic [8:0]  sec;
  logic [8:0]  rd_sec;
  logic        bp_hit;
  logic        bp_any;
  logic        sec_locked;
  logic        any_locked;
  logic        modifying;
  logic        need_check;

  // byte-lane merge for strobed writes
  function automatic logic [31:0] strb_merge(input logic [31:0] cur,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    r = cur;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // raw command code to operation
  function automatic fawp_op_e op_map(input logic [3:0] code);
    fawp_op_e o;
    o = OP_BAD;
    case (code)
      `FAWP_CODE_NOP:    o = OP_NOP;
      `FAWP_CODE_WREN:   o = OP_WREN;
      `FAWP_CODE_WRDI:   o = OP_WRDI;
      `FAWP_CODE_PROG:   o = OP_PROG;
      `FAWP_CODE_ESUB:   o = OP_ERASE_SUB;
      `FAWP_CODE_ESEC:   o = OP_ERASE_SEC;
      `FAWP_CODE_EBULK:  o = OP_ERASE_BULK;
      `FAWP_CODE_EPAGE:  o = OP_ERASE_PAGE;
      `FAWP_CODE_WRLOCK: o = OP_WR_LOCK;
      `FAWP_CODE_WRSTAT: o = OP_WR_STATUS;
      `FAWP_CODE_OTP:    o = OP_OTP_PROG;
      default:           o = OP_BAD;
    endcase
    return o;
  endfunction

  assign wr_fire = aw_have_r & w_have_r & ~bvalid_r;

  // write address decode
  always_comb begin
    case (aw_addr_r)
      `FAWP_OFS_CMD, `FAWP_OFS_ADDR, `FAWP_OFS_DATA, `FAWP_OFS_OLD: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // read mux; sector lock bits shown for the sector under addr_r
  assign rd_sec = addr_r[`FAWP_SEC_HI:`FAWP_SEC_LO];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    case (araddr)
      `FAWP_OFS_CMD:    rd_word = {28'h000_0000, code_r};
      `FAWP_OFS_ADDR:   rd_word = {7'h00, addr_r};
      `FAWP_OFS_DATA:   rd_word = data_r;
      `FAWP_OFS_OLD:    rd_word = old_r;
      `FAWP_OFS_STATUS: rd_word = {19'h0_0000, prot_r, res_r, 3'h0, wel_r};
      `FAWP_OFS_RESULT: rd_word = merged_r;
      `FAWP_OFS_LOCK:   rd_word = {30'h0000_0000, ldown_r[rd_sec], wlock_r[rd_sec]};
      default:          rd_ok   = 1'b0;
    endcase
  end

  // axi4-lite channel handshakes
  always_comb begin
    aw_have_nxt = aw_have_r;
    aw_addr_nxt = aw_addr_r;
    w_have_nxt  = w_have_r;
    w_data_nxt  = w_data_r;
    w_strb_nxt  = w_strb_r;
    bvalid_nxt  = bvalid_r;
    bresp_nxt   = bresp_r;
    arready_nxt = arready_r;
    rvalid_nxt  = rvalid_r;
    rdata_nxt   = rdata_r;
    rresp_nxt   = rresp_r;
    if (awvalid && awready_r) begin
      aw_have_nxt = 1'b1;
      aw_addr_nxt = awaddr;
    end
    if (wvalid && wready_r) begin
      w_have_nxt = 1'b1;
      w_data_nxt = wdata;
      w_strb_nxt = wstrb;
    end
    if (wr_fire) begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = wr_ok ? `FAWP_RESP_OKAY : `FAWP_RESP_SLVERR;
    end
    if (bvalid_r && bready) begin
      bvalid_nxt  = 1'b0;
      aw_have_nxt = 1'b0;
      w_have_nxt  = 1'b0;
    end
    if (arvalid && arready_r) begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rdata_nxt   = rd_word;
      rresp_nxt   = rd_ok ? `FAWP_RESP_OKAY : `FAWP_RESP_SLVERR;
    end
    if (rvalid_r && rready) begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
    awready_nxt = ~aw_have_nxt;
    wready_nxt  = ~w_have_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_have_r  <= 1'b0;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
      awready_r <= 1'b1;
      wready_r  <= 1'b1;
      bvalid_r  <= 1'b0;
      bresp_r   <= `FAWP_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `FAWP_RESP_OKAY;
    end else begin
      aw_have_r <= aw_have_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_have_r  <= w_have_nxt;
      w_data_r  <= w_data_nxt;
      w_strb_r  <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r  <= wready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // software registers; a command write launches one evaluation
  always_comb begin
    addr_nxt   = addr_r;
    data_nxt   = data_r;
    old_nxt    = old_r;
    code_nxt   = code_r;
    cmd_nxt    = cmd_r;
    cmd_go_nxt = 1'b0;
    wr_word    = 32'h0000_0000;
    if (wr_fire && wr_ok) begin
      case (aw_addr_r)
        `FAWP_OFS_CMD: begin
          wr_word        = strb_merge({cmd_r.pulses, 12'h000, code_r}, w_data_r, w_strb_r);
          code_nxt       = wr_word[`FAWP_CMD_OP_HI:0];
          cmd_nxt.op     = op_map(wr_word[`FAWP_CMD_OP_HI:0]);
          cmd_nxt.pulses = wr_word[`FAWP_CMD_CNT_HI:`FAWP_CMD_CNT_LO];
          cmd_nxt.addr   = addr_r;
          cmd_nxt.data   = data_r;
          cmd_go_nxt     = 1'b1;
        end
        `FAWP_OFS_ADDR: begin
          wr_word  = strb_merge({7'h00, addr_r}, w_data_r, w_strb_r);
          addr_nxt = wr_word[`FAWP_ADDR_W-1:0];
        end
        `FAWP_OFS_DATA: data_nxt = strb_merge(data_r, w_data_r, w_strb_r);
        `FAWP_OFS_OLD:  old_nxt  = strb_merge(old_r, w_data_r, w_strb_r);
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_r   <= '0;
      data_r   <= 32'h0000_0000;
      old_r    <= 32'hffff_ffff;
      code_r   <= `FAWP_CODE_NOP;
      cmd_r    <= '0;
      cmd_go_r <= 1'b0;
    end else begin
      addr_r   <= addr_nxt;
      data_r   <= data_nxt;
      old_r    <= old_nxt;
      code_r   <= code_nxt;
      cmd_r    <= cmd_nxt;
      cmd_go_r <= cmd_go_nxt;
    end
  end

  // sector of the pending command and its protection
  assign sec        = cmd_r.addr[`FAWP_SEC_HI:`FAWP_SEC_LO]; // RULE17
  assign sec_locked = wlock_r[sec]; // RULE9
  assign any_locked = |wlock_r;

  fawp_bp_decode u_bp (
    .size        (prot_r.size),
    .from_bottom (prot_r.from_bottom),
    .sector      (sec),
    .hit         (bp_hit),
    .any         (bp_any)
  );

  always_comb begin
    case (cmd_r.op)
      OP_PROG, OP_ERASE_SUB, OP_ERASE_SEC, OP_ERASE_BULK,
      OP_WR_LOCK, OP_WR_STATUS, OP_OTP_PROG: modifying = 1'b1;
      default:                               modifying = 1'b0;
    endcase
    need_check = modifying;
  end

  // command evaluation: pulse count, latch, locks, region, pin
  always_comb begin
    wlock_nxt        = wlock_r;
    ldown_nxt        = ldown_r;
    prot_nxt         = prot_r;
    wel_nxt          = wel_r;
    res_nxt          = res_r;
    merged_nxt       = merged_r;
    grant_nxt        = grant_r;
    grant_valid_nxt  = 1'b0;
    reject_valid_nxt = 1'b0;
    if (cmd_go_r) begin
      res_nxt = RES_OK;
      if (cmd_r.op == OP_ERASE_PAGE || cmd_r.op == OP_BAD) begin
        res_nxt = RES_BAD_OP; // RULE2
      end else if (need_check && cmd_r.pulses[2:0] != 3'h0) begin
        res_nxt = RES_BAD_COUNT; // RULE7
      end else if (need_check && !wel_r) begin
        res_nxt = RES_NO_WEL; // RULE8
      end else begin
        case (cmd_r.op)
          OP_WR_LOCK: begin
            if (ldown_r[sec]) begin
              res_nxt = RES_LOCKDOWN; // RULE10 RULE11
            end
          end
          OP_WR_STATUS: begin
            if (!write_protect_n) begin
              res_nxt = RES_WP_PIN; // RULE16
            end
          end
          OP_PROG, OP_ERASE_SUB, OP_ERASE_SEC: begin
            if (sec_locked) begin
              res_nxt = RES_LOCKED; // RULE9 RULE18
            end else if (bp_hit) begin
              res_nxt = RES_BP; // RULE18
            end
          end
          OP_ERASE_BULK: begin
            if (any_locked) begin
              res_nxt = RES_LOCKED; // RULE18
            end else if (bp_any) begin
              res_nxt = RES_BP; // RULE18
            end
          end
          OP_OTP_PROG: begin
            if (cmd_r.addr[`FAWP_ADDR_W-1:`FAWP_OTP_HI+1] != '0) begin
              res_nxt = RES_BAD_ADDR; // RULE5
            end
          end
          default: ;
        endcase
      end
      if (res_nxt != RES_OK) begin
        reject_valid_nxt = modifying;
      end else begin
        case (cmd_r.op)
          OP_WREN: wel_nxt = 1'b1; // RULE8
          OP_WRDI: wel_nxt = 1'b0;
          OP_WR_LOCK: begin
            wlock_nxt[sec] = cmd_r.data[0]; // RULE11 RULE12
            ldown_nxt[sec] = cmd_r.data[1]; // RULE10
          end
          OP_WR_STATUS: begin
            prot_nxt.size        = cmd_r.data[3:0];
            prot_nxt.from_bottom = cmd_r.data[4];
          end
          OP_PROG, OP_OTP_PROG: merged_nxt = old_r & cmd_r.data; // RULE1 RULE6
          OP_ERASE_SUB, OP_ERASE_SEC, OP_ERASE_BULK: merged_nxt = 32'hffff_ffff; // RULE1
          default: ;
        endcase
        if (modifying) begin
          wel_nxt            = 1'b0;
          grant_valid_nxt    = 1'b1;
          grant_nxt.op       = cmd_r.op;
          grant_nxt.otp      = (cmd_r.op == OP_OTP_PROG); // RULE5
          grant_nxt.sector   = sec; // RULE3
          grant_nxt.subsector = cmd_r.addr[`FAWP_SEC_HI:`FAWP_SUB_LO]; // RULE4 RULE17
          grant_nxt.page     = cmd_r.addr[`FAWP_SEC_HI:`FAWP_PAGE_LO]; // RULE4 RULE6
          grant_nxt.addr     = grant_nxt.otp ? {19'h0_0000, cmd_r.addr[`FAWP_OTP_HI:0]}
                                             : cmd_r.addr;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wlock_r        <= `FAWP_WLOCK_RST; // RULE13
      ldown_r        <= `FAWP_LDOWN_RST; // RULE10
      prot_r         <= `FAWP_PROT_RST;
      wel_r          <= 1'b0;
      res_r          <= RES_NONE;
      merged_r       <= 32'hffff_ffff;
      grant_r        <= '0;
      grant_valid_r  <= 1'b0;
      reject_valid_r <= 1'b0;
    end else begin
      wlock_r        <= wlock_nxt;
      ldown_r        <= ldown_nxt;
      prot_r         <= prot_nxt;
      wel_r          <= wel_nxt;
      res_r          <= res_nxt;
      merged_r       <= merged_nxt;
      grant_r        <= grant_nxt;
      grant_valid_r  <= grant_valid_nxt;
      reject_valid_r <= reject_valid_nxt;
    end
  end

  // outputs straight from flops
  assign awready      = awready_r;
  assign wready       = wready_r;
  assign bvalid       = bvalid_r;
  assign bresp        = bresp_r;
  assign arready      = arready_r;
  assign rvalid       = rvalid_r;
  assign rdata        = rdata_r;
  assign rresp        = rresp_r;
  assign grant_valid  = grant_valid_r;
  assign grant        = grant_r;
  assign reject_valid = reject_valid_r;
  assign wel          = wel_r;

endmodule // fawp_top

// ===== fawp_cfg.svh
`ifndef FAWP_CFG_SVH
`define FAWP_CFG_SVH

// array geometry
`define FAWP_ARRAY_BYTES  33554432
`define FAWP_SECTORS      512
`define FAWP_SUBSECTORS   8192
`define FAWP_PAGES        131072
`define FAWP_PAGE_BYTES   256
`define FAWP_OTP_BYTES    64
`define FAWP_ADDR_W       25
`define FAWP_SEC_HI       24
`define FAWP_SEC_LO       16
`define FAWP_SUB_LO       12
`define FAWP_PAGE_LO      8
`define FAWP_OTP_HI       5

// register byte offsets
`define FAWP_OFS_CMD      8'h00
`define FAWP_OFS_ADDR     8'h04
`define FAWP_OFS_DATA     8'h08
`define FAWP_OFS_OLD      8'h0c
`define FAWP_OFS_STATUS   8'h10
`define FAWP_OFS_RESULT   8'h14
`define FAWP_OFS_LOCK     8'h18

// command register fields
`define FAWP_CMD_OP_HI    3
`define FAWP_CMD_CNT_LO   16
`define FAWP_CMD_CNT_HI   31

// raw command codes
`define FAWP_CODE_NOP     4'h0
`define FAWP_CODE_WREN    4'h1
`define FAWP_CODE_WRDI    4'h2
`define FAWP_CODE_PROG    4'h3
`define FAWP_CODE_ESUB    4'h4
`define FAWP_CODE_ESEC    4'h5
`define FAWP_CODE_EBULK   4'h6
`define FAWP_CODE_EPAGE   4'h7
`define FAWP_CODE_WRLOCK  4'h8
`define FAWP_CODE_WRSTAT  4'h9
`define FAWP_CODE_OTP     4'ha

// protection
`define FAWP_BP_ALL       4'ha
`define FAWP_WLOCK_RST    {512{1'b1}}
`define FAWP_LDOWN_RST    {512{1'b0}}
`define FAWP_PROT_RST     5'h00

// axi responses
`define FAWP_RESP_OKAY    2'h0
`define FAWP_RESP_SLVERR  2'h2

`endif

// ===== fawp_pkg.sv
package fawp_pkg;
`include "fawp_cfg.svh"

  typedef enum logic [3:0] {
    OP_NOP, OP_WREN, OP_WRDI, OP_PROG, OP_ERASE_SUB, OP_ERASE_SEC,
    OP_ERASE_BULK, OP_ERASE_PAGE, OP_WR_LOCK, OP_WR_STATUS, OP_OTP_PROG, OP_BAD
  } fawp_op_e;

  typedef enum logic [3:0] {
    RES_NONE, RES_OK, RES_BAD_COUNT, RES_NO_WEL, RES_LOCKED, RES_BP,
    RES_LOCKDOWN, RES_WP_PIN, RES_BAD_OP, RES_BAD_ADDR
  } fawp_res_e;

  typedef struct packed {
    fawp_op_e                 op;
    logic [15:0]              pulses;
    logic [`FAWP_ADDR_W-1:0]  addr;
    logic [31:0]              data;
  } fawp_cmd_s;

  typedef struct packed {
    fawp_op_e                 op;
    logic                     otp;
    logic [8:0]               sector;
    logic [12:0]              subsector;
    logic [16:0]              page;
    logic [`FAWP_ADDR_W-1:0]  addr;
  } fawp_grant_s;

  typedef struct packed {
    logic [3:0] size;
    logic       from_bottom;
  } fawp_prot_s;

endpackage

// ===== fawp_bp_decode.sv
`timescale 1ns/1ps
`include "fawp_cfg.svh"

module fawp_bp_decode
  import fawp_pkg::*;
(
  input  wire logic [3:0] size,
  input  wire logic       from_bottom,
  input  wire logic [8:0] sector,
  output logic            hit,
  output logic            any
);

  logic [3:0] sh;

  // protected region: 2^(n-1) sectors at one end, all from n=10
  always_comb begin
    sh  = size - 4'h1;
    any = (size != 4'h0);
    if (size == 4'h0) begin
      hit = 1'b0;
    end else if (size >= `FAWP_BP_ALL) begin
      hit = 1'b1; // RULE14 RULE15
    end else if (from_bottom) begin
      hit = ((sector >> sh) == 9'h000); // RULE15
    end else begin
      hit = ((sector >> sh) == (9'h1ff >> sh)); // RULE14
    end
  end

endmodule // fawp_bp_decode

// ===== fawp_top_asserts.sv
`timescale 1ns/1ps
module fawp_top_asserts
  import fawp_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] rdata,
  input  wire logic        rvalid,
  input  wire logic        rready,
  input  wire logic        grant_valid,
  input  wire fawp_grant_s grant,
  input  wire logic        reject_valid,
  input  wire logic        wel
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // a grant is one pulse, then quiet
  sequence s_grant_pulse;
    grant_valid ##1 !grant_valid;
  endsequence
  // a grant follows a write response while the latch was set
  sequence s_launched;
    $past(bvalid) && $past(wel);
  endsequence

  a_grant_one_cycle: assert property (grant_valid |-> s_grant_pulse)
    else $error("grant pulse longer than one cycle");
  a_grant_needs_wel: assert property ($rose(grant_valid) |-> s_launched)
    else $error("grant without write-enable latch");
  a_grant_clears_wel: assert property (grant_valid |-> !wel)
    else $error("latch still set after grant");
  a_grant_or_reject: assert property (!(grant_valid && reject_valid))
    else $error("grant and reject together");
  a_grant_geometry: assert property (grant_valid && !grant.otp |->
    grant.sector == grant.addr[24:16] && grant.subsector == grant.addr[24:12]
    && grant.page == grant.addr[24:8])
    else $error("granted sector index does not match address");
  a_otp_in_range: assert property (grant_valid && grant.otp |-> grant.addr[24:6] == 19'h0)
    else $error("one-time area granted outside its 64 bytes");
  a_no_page_erase: assert property (grant_valid |-> grant.op != OP_ERASE_PAGE)
    else $error("page erase granted");
  a_bresp_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
endmodule // fawp_top_asserts

bind fawp_top fawp_top_asserts chk_u (
  .aclk(aclk), .aresetn(aresetn), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .rdata(rdata), .rvalid(rvalid), .rready(rready), .grant_valid(grant_valid),
  .grant(grant), .reject_valid(reject_valid), .wel(wel)
);

// ===== fawp_host_model.sv
`timescale 1ns/1ps
`include "fawp_cfg.svh"
module fawp_host_model (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  // idle bus at time zero
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
  end

  // address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1; // late ready makes the slave hold its answer
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  // one read, address released when taken, then wait for the data
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // write-enable issued ahead of a modifying command
  task automatic wren();
    logic [1:0] r;
    wr(`FAWP_OFS_CMD, {16'd8, 12'h0, `FAWP_CODE_WREN}, r);
  endtask
endmodule // fawp_host_model

// ===== fawp_top_tb_top.sv
`timescale 1ns/1ps
`include "fawp_cfg.svh"
module fawp_top_tb_top
  import fawp_pkg::*;
;
  logic        aclk, aresetn, write_protect_n;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, grant_valid, reject_valid, wel;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_r;
  fawp_grant_s grant;
  int          fails, checks_done, cyc, rejects;

  fawp_top dut_u (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .write_protect_n, .grant_valid, .grant, .reject_valid, .wel);
  fawp_host_model host_u (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready);

  // 200 MHz clock
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge aclk) begin
    cyc++;
    rejects += reject_valid;
    if (cyc == 30000) begin
      fails++;
      stop_test();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
    logic [1:0] r;
    host_u.wr(a, d, r);
    check("bresp", {30'h0, exp}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a);
    host_u.rd(a, rd_d, rd_r);
  endtask

  // launch a command, then read back its result code
  task automatic run(input logic [3:0] code, input logic [15:0] pulses, input logic [3:0] exp);
    wr(`FAWP_OFS_CMD, {pulses, 12'h0, code}, `FAWP_RESP_OKAY);
    rd(`FAWP_OFS_STATUS);
    check("result", {28'h0, exp}, {28'h0, rd_d[7:4]});
  endtask

  task automatic en_run(input logic [3:0] code, input logic [3:0] exp);
    host_u.wren();
    run(code, 16'd40, exp);
  endtask

  task automatic set_lock(input logic [8:0] sec, input logic [1:0] bits, input logic [3:0] exp);
    wr(`FAWP_OFS_ADDR, {7'h0, sec, 16'h0}, `FAWP_RESP_OKAY);
    wr(`FAWP_OFS_DATA, {30'h0, bits}, `FAWP_RESP_OKAY);
    en_run(`FAWP_CODE_WRLOCK, exp);
  endtask

  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  // sectors 0 and 511 locked, latch clear after reset
  task automatic t_reset_state();
    rd(`FAWP_OFS_STATUS);
    check("status", 32'h0, rd_d);
    rd(`FAWP_OFS_LOCK);
    check("lock sector 0", 32'h1, rd_d);
    wr(`FAWP_OFS_ADDR, {7'h0, 9'd511, 16'h0}, `FAWP_RESP_OKAY);
    rd(`FAWP_OFS_LOCK);
    check("lock sector 511", 32'h1, rd_d);
  endtask

  // latch, byte count and lock refusals
  task automatic t_refusals();
    wr(`FAWP_OFS_ADDR, 32'h0, `FAWP_RESP_OKAY);
    run(`FAWP_CODE_PROG, 16'd40, RES_NO_WEL);
    host_u.wren();
    run(`FAWP_CODE_PROG, 16'd41, RES_BAD_COUNT);
    run(`FAWP_CODE_ESEC, 16'd4, RES_BAD_COUNT);
    check("wel kept", 32'h1, {31'h0, rd_d[0]});
    run(`FAWP_CODE_PROG, 16'd40, RES_LOCKED);
    en_run(`FAWP_CODE_EPAGE, RES_BAD_OP);
    check("rejects", 32'd4, rejects);
  endtask

  // unlock, program, erase, then lock down until reset
  task automatic t_prog_erase();
    set_lock(9'd5, 2'b00, RES_OK);
    rd(`FAWP_OFS_LOCK);
    check("unlocked", 32'h0, rd_d);
    wr(`FAWP_OFS_ADDR, 32'h0005_1234, `FAWP_RESP_OKAY);
    wr(`FAWP_OFS_OLD, 32'hffff_00ff, `FAWP_RESP_OKAY);
    wr(`FAWP_OFS_DATA, 32'h0f0f_0f0f, `FAWP_RESP_OKAY);
    en_run(`FAWP_CODE_PROG, RES_OK);
    rd(`FAWP_OFS_RESULT);
    check("programmed word", 32'h0f0f_000f, rd_d);
    check("sector", 32'd5, {23'h0, grant.sector});
    check("subsector", 32'd81, {19'h0, grant.subsector});
    check("page", 32'h512, {15'h0, grant.page});
    en_run(`FAWP_CODE_ESUB, RES_OK);
    rd(`FAWP_OFS_RESULT);
    check("erased word", 32'hffff_ffff, rd_d);
    en_run(`FAWP_CODE_ESEC, RES_OK);
    set_lock(9'd5, 2'b11, RES_OK);
    set_lock(9'd5, 2'b00, RES_LOCKDOWN);
    en_run(`FAWP_CODE_PROG, RES_LOCKED);
    do_reset();
    wr(`FAWP_OFS_ADDR, 32'h0005_0000, `FAWP_RESP_OKAY);
    rd(`FAWP_OFS_LOCK);
    check("lock after reset", 32'h1, rd_d);
  endtask

  // every bottom setting and edge size against boundary sectors
  task automatic t_block_protect();
    logic [8:0] secs [6] = '{9'd0, 9'd1, 9'd255, 9'd256, 9'd510, 9'd511};
    logic [3:0] ns [6] = '{4'h0, 4'h1, 4'h2, 4'h9, 4'ha, 4'hf};
    int span;
    logic prot;
    foreach (secs[i]) set_lock(secs[i], 2'b00, RES_OK);
    for (int b = 0; b < 2; b++) begin
      foreach (ns[k]) begin
        wr(`FAWP_OFS_DATA, {27'h0, b[0], ns[k]}, `FAWP_RESP_OKAY);
        en_run(`FAWP_CODE_WRSTAT, RES_OK);
        check("protect bits", {27'h0, ns[k], b[0]}, {27'h0, rd_d[12:8]});
        span = (ns[k] == 4'h0) ? 0 : 1 << (ns[k] - 1);
        foreach (secs[i]) begin
          prot = (ns[k] >= 4'ha) || (b == 1 ? secs[i] < span : secs[i] >= 512 - span);
          wr(`FAWP_OFS_ADDR, {7'h0, secs[i], 16'h0}, `FAWP_RESP_OKAY);
          en_run(`FAWP_CODE_PROG, prot ? RES_BP : RES_OK);
        end
      end
    end
    en_run(`FAWP_CODE_EBULK, RES_LOCKED);
  endtask

  // pin low freezes protect bits; one-time area bounds; unmapped places
  task automatic t_pin_otp_bus();
    @(posedge aclk);
    write_protect_n <= 1'b0;
    wr(`FAWP_OFS_DATA, 32'h0, `FAWP_RESP_OKAY);
    en_run(`FAWP_CODE_WRSTAT, RES_WP_PIN);
    check("frozen bits", 32'h1f, {27'h0, rd_d[12:8]});
    @(posedge aclk);
    write_protect_n <= 1'b1;
    wr(`FAWP_OFS_ADDR, 32'h40, `FAWP_RESP_OKAY);
    en_run(`FAWP_CODE_OTP, RES_BAD_ADDR);
    wr(`FAWP_OFS_ADDR, 32'h3f, `FAWP_RESP_OKAY);
    en_run(`FAWP_CODE_OTP, RES_OK);
    check("otp grant", 32'h1, {31'h0, grant.otp});
    wr(8'h1c, 32'h0, `FAWP_RESP_SLVERR);
    wr(`FAWP_OFS_STATUS, 32'h0, `FAWP_RESP_SLVERR);
    rd(8'h1c);
    check("unmapped read", {30'h0, `FAWP_RESP_SLVERR}, {30'h0, rd_r});
  endtask

  // main sequence
  initial begin
    aresetn = 1'b0;
    write_protect_n = 1'b1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_state();
    t_refusals();
    t_prog_erase();
    t_block_protect();
    t_pin_otp_bus();
    stop_test();
  end
endmodule // fawp_top_tb_top
